//--- design/ctc_pio_pkg.sv
// Shared constants and types for the counter/timer and parallel port block.
package ctc_pio_pkg;

  localparam logic [7:0] P1_DIR_ADDR = 8'hE0;
  localparam logic [7:0] P1_DATA_ADDR = 8'hE1;
  localparam logic [7:0] P2_DIR_ADDR = 8'hE2;
  localparam logic [7:0] P2_DATA_ADDR = 8'hE3;
  localparam logic [7:0] CH0_ADDR = 8'hE4;
  localparam logic [7:0] CH3_ADDR = 8'hE7;

  localparam int NUM_CH = 4;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam logic [7:0] VEC_BASE_MASK = 8'hF8;

  // Control word bit positions.
  localparam int CW_CTRL = 0;
  localparam int CW_RESET = 1;
  localparam int CW_TC_NEXT = 2;
  localparam int CW_EDGE = 4;
  localparam int CW_PRESCALE = 5;
  localparam int CW_MODE = 6;
  localparam int CW_INT_EN = 7;

  // Prescaler reloads: divide by 16 or by 256.
  localparam logic [7:0] PRESCALE_SHORT = 8'h0F;
  localparam logic [7:0] PRESCALE_LONG = 8'hFF;

  // Shared pins: triggers on bits 3:0, zero-count outputs on bits 7:4.
  localparam int TRIG_LSB = 0;
  localparam int ZC_LSB = 4;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } io_req_s;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] oe_n;
  } pin_drive_s;

  typedef enum {CH_STOPPED, CH_LOAD_TC, CH_RUNNING} ch_state_e;

endpackage

//--- design/timer_channel.sv
// One counter/timer channel: control word, time constant, prescaler and down-counter.
module timer_channel (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register access
  input wire logic wr,
  input wire logic [7:0] wdata,
  // Trigger level, already filtered
  input wire logic trig,
  // Interrupt acknowledge for this channel
  input wire logic int_clr,
  // Status
  output logic [7:0] count,
  output logic zc,
  output logic int_pending,
  output logic tc_expected
);

  typedef struct packed {
    ctc_pio_pkg::ch_state_e state;
    logic [7:0] ctrl;
    logic [7:0] tc;
    logic [7:0] count;
    logic [7:0] pre;
    logic trig_prev;
    logic zc;
    logic pending;
  } ch_s;

  ch_s q;
  ch_s d;
  logic tick;
  logic edge_seen;
  logic [7:0] pre_reload;

  assign count = q.count;
  assign zc = q.zc;
  assign int_pending = q.pending;
  assign tc_expected = (q.state == ctc_pio_pkg::CH_LOAD_TC);

  always_comb begin
    d = q;
    d.zc = 1'b0;
    d.trig_prev = trig;
    pre_reload = q.ctrl[ctc_pio_pkg::CW_PRESCALE] ? ctc_pio_pkg::PRESCALE_LONG : ctc_pio_pkg::PRESCALE_SHORT;
    edge_seen = q.ctrl[ctc_pio_pkg::CW_EDGE] ? (trig & ~q.trig_prev) : (~trig & q.trig_prev);
    tick = 1'b0;
    if (int_clr) begin
      d.pending = 1'b0;
    end
    if (q.state == ctc_pio_pkg::CH_RUNNING) begin
      if (q.ctrl[ctc_pio_pkg::CW_MODE]) begin
        tick = edge_seen;
      end else if (q.pre == 8'h00) begin
        d.pre = pre_reload;
        tick = 1'b1;
      end else begin
        d.pre = q.pre - 8'h01;
      end
      if (tick) begin
        // A time constant of zero gives a full 256-count period.
        if (q.count == 8'h01) begin
          d.count = q.tc;
          d.zc = 1'b1;
          if (q.ctrl[ctc_pio_pkg::CW_INT_EN]) begin
            d.pending = 1'b1;
          end
        end else begin
          d.count = q.count - 8'h01;
        end
      end
    end
    if (wr) begin
      if (q.state == ctc_pio_pkg::CH_LOAD_TC) begin
        d.tc = wdata;
        d.count = wdata;
        d.pre = pre_reload;
        d.state = ctc_pio_pkg::CH_RUNNING;
      end else if (wdata[ctc_pio_pkg::CW_CTRL]) begin
        d.ctrl = wdata;
        if (wdata[ctc_pio_pkg::CW_TC_NEXT]) begin
          d.state = ctc_pio_pkg::CH_LOAD_TC;
        end else if (wdata[ctc_pio_pkg::CW_RESET]) begin
          d.state = ctc_pio_pkg::CH_STOPPED;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{state: ctc_pio_pkg::CH_STOPPED, ctrl: ctc_pio_pkg::CTRL_RESET, tc: 8'h00, count: 8'h00,
             pre: 8'h00, trig_prev: 1'b0, zc: 1'b0, pending: 1'b0};
    end else begin
      q <= d;
    end
  end

endmodule

//--- design/ctc_pio.sv
// Top of the four-channel counter/timer with two parallel ports on the internal I/O bus.
module ctc_pio (
  // Clock and reset, clock is the processor system clock
  input wire logic core_clk,
  input wire logic sys_rst,
  // Internal I/O bus
  input wire ctc_pio_pkg::io_req_s io_req,
  output logic [7:0] io_rdata,
  // Interrupt acknowledge and return from interrupt
  input wire logic int_ack,
  input wire logic int_return,
  output logic int_req,
  output logic [7:0] int_vector,
  // Daisy chain
  input wire logic daisy_in,
  output logic daisy_out,
  // Pin use select, configuration bit D0
  input wire logic timer_pin_select,
  // First port pins
  input wire logic [7:0] p1_pin_in,
  output ctc_pio_pkg::pin_drive_s p1_pin,
  // Second port pins
  input wire logic [7:0] p2_pin_in,
  output ctc_pio_pkg::pin_drive_s p2_pin
);

  typedef struct packed {
    logic [7:0] p1_dir;
    logic [7:0] p1_data;
    logic [7:0] p2_dir;
    logic [7:0] p2_data;
    // Synchroniser stages and filtered levels of the pins.
    logic [7:0] p1_s1;
    logic [7:0] p1_s2;
    logic [7:0] p1_s3;
    logic [7:0] p1_lvl;
    logic [7:0] p2_s1;
    logic [7:0] p2_s2;
    logic [7:0] p2_s3;
    logic [7:0] p2_lvl;
    logic [2:0] dc_s;
    logic dc_lvl;
    logic [7:0] rdata;
    ctc_pio_pkg::pin_drive_s p1_pin;
    ctc_pio_pkg::pin_drive_s p2_pin;
    // Interrupt and daisy-chain state.
    logic [7:0] vec_base;
    logic in_service;
    logic daisy_out;
    logic int_req;
    logic [7:0] vector;
  } top_s;

  top_s q;
  top_s d;

  logic [ctc_pio_pkg::NUM_CH-1:0] ch_wr;
  logic [ctc_pio_pkg::NUM_CH-1:0] ch_clr;
  logic [ctc_pio_pkg::NUM_CH-1:0] ch_zc;
  logic [ctc_pio_pkg::NUM_CH-1:0] ch_pend;
  logic [ctc_pio_pkg::NUM_CH-1:0] ch_tc;
  logic [ctc_pio_pkg::NUM_CH-1:0] ch_trig;
  logic [7:0] ch_count [ctc_pio_pkg::NUM_CH];
  logic [1:0] ch_idx;
  logic ch_hit;

  // The channel registers form one contiguous block, so a single range test selects them.
  assign ch_hit = (io_req.addr >= ctc_pio_pkg::CH0_ADDR) && (io_req.addr <= ctc_pio_pkg::CH3_ADDR);
  assign ch_idx = io_req.addr[1:0];
  // Triggers only reach the channels while the pins belong to the timer.
  assign ch_trig = timer_pin_select ? q.p1_lvl[ctc_pio_pkg::TRIG_LSB +: ctc_pio_pkg::NUM_CH] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < ctc_pio_pkg::NUM_CH; gi++) begin : g_ch
      assign ch_wr[gi] = io_req.wr && ch_hit && (ch_idx == 2'(gi));
      timer_channel u_ch (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr(ch_wr[gi]),
        .wdata(io_req.wdata),
        .trig(ch_trig[gi]),
        .int_clr(ch_clr[gi]),
        .count(ch_count[gi]),
        .zc(ch_zc[gi]),
        .int_pending(ch_pend[gi]),
        .tc_expected(ch_tc[gi])
      );
    end
  endgenerate

  // Lowest channel number wins the acknowledge.
  // Pending flags come from registered channel state, so a flag raised in the acknowledge cycle waits its turn.
  always_comb begin
    ch_clr = '0;
    if (int_ack && !q.in_service) begin
      if (ch_pend[0]) begin
        ch_clr[0] = 1'b1;
      end else if (ch_pend[1]) begin
        ch_clr[1] = 1'b1;
      end else if (ch_pend[2]) begin
        ch_clr[2] = 1'b1;
      end else if (ch_pend[3]) begin
        ch_clr[3] = 1'b1;
      end
    end
  end

  always_comb begin
    d = q;
    // Pin synchronisers: a change counts once the second and third stages agree.
    d.p1_s1 = p1_pin_in;
    d.p1_s2 = q.p1_s1;
    d.p1_s3 = q.p1_s2;
    d.p2_s1 = p2_pin_in;
    d.p2_s2 = q.p2_s1;
    d.p2_s3 = q.p2_s2;
    // The daisy-chain input is a pin as well and gets the same filter.
    d.dc_s = {q.dc_s[1:0], daisy_in};
    for (int i = 0; i < 8; i++) begin
      if (q.p1_s2[i] == q.p1_s3[i]) begin
        d.p1_lvl[i] = q.p1_s3[i];
      end
      if (q.p2_s2[i] == q.p2_s3[i]) begin
        d.p2_lvl[i] = q.p2_s3[i];
      end
    end
    if (q.dc_s[1] == q.dc_s[2]) begin
      d.dc_lvl = q.dc_s[2];
    end

    if (io_req.wr) begin
      if (io_req.addr == ctc_pio_pkg::P1_DIR_ADDR) begin
        d.p1_dir = io_req.wdata;
      end else if (io_req.addr == ctc_pio_pkg::P1_DATA_ADDR) begin
        d.p1_data = io_req.wdata;
      end else if (io_req.addr == ctc_pio_pkg::P2_DIR_ADDR) begin
        d.p2_dir = io_req.wdata;
      end else if (io_req.addr == ctc_pio_pkg::P2_DATA_ADDR) begin
        d.p2_data = io_req.wdata;
      // Bit 0 clear to channel 0 is the vector base, unless that channel awaits a time constant.
      end else if (io_req.addr == ctc_pio_pkg::CH0_ADDR && !io_req.wdata[ctc_pio_pkg::CW_CTRL] && !ch_tc[0]) begin
        d.vec_base = io_req.wdata & ctc_pio_pkg::VEC_BASE_MASK;
      end
    end

    if (io_req.rd) begin
      if (io_req.addr == ctc_pio_pkg::P1_DIR_ADDR) begin
        d.rdata = q.p1_dir;
      end else if (io_req.addr == ctc_pio_pkg::P1_DATA_ADDR) begin
        d.rdata = (q.p1_dir & q.p1_data) | (~q.p1_dir & q.p1_lvl);
      end else if (io_req.addr == ctc_pio_pkg::P2_DIR_ADDR) begin
        d.rdata = q.p2_dir;
      end else if (io_req.addr == ctc_pio_pkg::P2_DATA_ADDR) begin
        d.rdata = (q.p2_dir & q.p2_data) | (~q.p2_dir & q.p2_lvl);
      end else if (ch_hit) begin
        d.rdata = ch_count[ch_idx];
      end else begin
        // A stray read of an unmapped address returns zero and changes nothing.
        d.rdata = 8'h00;
      end
    end

    // Port drive: a direction bit of one drives the pin, so enable goes low.
    d.p1_pin.value = q.p1_data;
    d.p1_pin.oe_n = ~q.p1_dir;
    d.p2_pin.value = q.p2_data;
    d.p2_pin.oe_n = ~q.p2_dir;
    if (timer_pin_select) begin
      // Timer use overrides the port on the first port's pins.
      // Bits 3:0 stay inputs because they carry the channel triggers.
      d.p1_pin.value[ctc_pio_pkg::ZC_LSB +: ctc_pio_pkg::NUM_CH] = ch_zc;
      d.p1_pin.oe_n = 8'h0F;
    end

    // Acknowledge returns the base with the channel number in bits 2:1.
    if (ch_clr != '0) begin
      d.in_service = 1'b1;
      d.vector = q.vec_base;
      if (ch_clr[1]) begin
        d.vector[2:1] = 2'd1;
      end else if (ch_clr[2]) begin
        d.vector[2:1] = 2'd2;
      end else if (ch_clr[3]) begin
        d.vector[2:1] = 2'd3;
      end
    // An acknowledge that takes a channel and a return in one cycle leave the block in service.
    end else if (int_return) begin
      d.in_service = 1'b0;
    end
    d.int_req = (|(ch_pend & ~ch_clr)) && !d.in_service && q.dc_lvl;
    d.daisy_out = q.dc_lvl && !d.in_service;
  end

  // Registered copy of all block state; every output is taken from here.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      // Outputs leave reset quiet: no request, chain closed, all pins inputs.
      q.rdata <= ctc_pio_pkg::DATA_RESET;
      q.int_req <= 1'b0;
      q.daisy_out <= 1'b0;
      q.in_service <= 1'b0;
      q.vector <= ctc_pio_pkg::VEC_RESET;
      q.p1_dir <= ctc_pio_pkg::DIR_RESET;
      q.p2_dir <= ctc_pio_pkg::DIR_RESET;
      q.p1_data <= ctc_pio_pkg::DATA_RESET;
      q.p2_data <= ctc_pio_pkg::DATA_RESET;
      q.p1_pin.oe_n <= 8'hFF;
      q.p2_pin.oe_n <= 8'hFF;
      q.vec_base <= ctc_pio_pkg::VEC_RESET;
    end else begin
      q <= d;
    end
  end

  assign io_rdata = q.rdata;
  assign int_req = q.int_req;
  assign int_vector = q.vector;
  assign daisy_out = q.daisy_out;
  assign p1_pin = q.p1_pin;
  assign p2_pin = q.p2_pin;

endmodule

//--- verif/ctc_pio_chk.sv
// Assertion checker for the counter/timer and parallel port block.
module ctc_pio_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Bus, interrupt and daisy chain
  input wire ctc_pio_pkg::io_req_s io_req,
  input wire logic [7:0] io_rdata,
  input wire logic int_ack,
  input wire logic int_req,
  input wire logic [7:0] int_vector,
  input wire logic daisy_in,
  input wire logic daisy_out,
  // Pins
  input wire logic timer_pin_select,
  input wire ctc_pio_pkg::pin_drive_s p1_pin,
  input wire ctc_pio_pkg::pin_drive_s p2_pin
);
  logic in_map;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  assign in_map = (io_req.addr[7:3] == 5'h1C);

  chk_reset_dirs: assert property ($past(sys_rst) |-> p1_pin.oe_n == 8'hFF && p2_pin.oe_n == 8'hFF)
    else $error("port left driven after reset");
  chk_rdata_hold: assert property (!io_req.rd |=> $stable(io_rdata))
    else $error("read data moved without a read");
  chk_unmapped_rd: assert property (io_req.rd && !in_map |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_dir_pin: assert property (io_req.wr && io_req.addr == ctc_pio_pkg::P2_DIR_ADDR |->
    ##2 p2_pin.oe_n == ~$past(io_req.wdata, 2)) else $error("direction write not on pins");
  chk_data_pin: assert property (io_req.wr && io_req.addr == ctc_pio_pkg::P2_DATA_ADDR |->
    ##2 p2_pin.value == $past(io_req.wdata, 2)) else $error("data write not on pins");
  chk_timer_owns: assert property (timer_pin_select [*3] |-> p1_pin.oe_n == 8'h0F)
    else $error("timer does not own first port pins");
  chk_ack_vec: assert property (int_ack && int_req |=> !int_req && !int_vector[0])
    else $error("acknowledge not taken");
  chk_vec_hold: assert property (!int_ack |=> $stable(int_vector))
    else $error("vector moved without acknowledge");
  chk_ack_daisy: assert property (int_ack && int_req |=> !daisy_out)
    else $error("chain open while in service");
  chk_daisy_low: assert property (!daisy_in [*6] |-> !daisy_out)
    else $error("chain open with input low");
endmodule

bind ctc_pio ctc_pio_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .io_req(io_req),
  .io_rdata(io_rdata), .int_ack(int_ack), .int_req(int_req), .int_vector(int_vector),
  .daisy_in(daisy_in), .daisy_out(daisy_out), .timer_pin_select(timer_pin_select),
  .p1_pin(p1_pin), .p2_pin(p2_pin));

//--- verif/pin_far_end.sv
// External circuit on one port, resolving each pin between block and outside driver.
module pin_far_end (
  // Block drive and outside level
  input wire ctc_pio_pkg::pin_drive_s drive,
  input wire logic [7:0] ext,
  // Resolved pin levels
  output logic [7:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  // The outside driver yields only on bits that the block drives.
  assign level = (~drive.oe_n & drive.value) | (drive.oe_n & ext);
endmodule

//--- verif/tb.sv
// Self-checking testbench for the counter/timer and parallel port block.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, sys_rst, int_ack, int_return, daisy_in, sel, int_req, daisy_out;
  ctc_pio_pkg::io_req_s io_req;
  ctc_pio_pkg::pin_drive_s p1_pin, p2_pin;
  logic [7:0] io_rdata, int_vector, p1_ext, p2_ext, p1_in, p2_in;
  int err_total, compares, cycles, n;

  ctc_pio u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .io_req(io_req), .io_rdata(io_rdata),
    .int_ack(int_ack), .int_return(int_return), .int_req(int_req), .int_vector(int_vector),
    .daisy_in(daisy_in), .daisy_out(daisy_out), .timer_pin_select(sel), .p1_pin_in(p1_in),
    .p1_pin(p1_pin), .p2_pin_in(p2_in), .p2_pin(p2_pin));
  pin_far_end u_far1 (.drive(p1_pin), .ext(p1_ext), .level(p1_in));
  pin_far_end u_far2 (.drive(p2_pin), .ext(p2_ext), .level(p2_in));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      results();
    end
  end

  task automatic results();
    $display("Checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge core_clk);
    io_req.wr = 1'b0;
  endtask

  // Waits one cycle beyond the answer, since read data holds until the next read.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge core_clk);
    io_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge core_clk);
    io_req.rd = 1'b0;
    @(negedge core_clk);
    check8(what, exp, io_rdata);
  endtask

  task automatic pulse(input logic ack);
    @(negedge core_clk);
    int_ack = ack;
    int_return = ~ack;
    @(negedge core_clk);
    int_ack = 1'b0;
    int_return = 1'b0;
  endtask

  task automatic wait_zc(input int b, output int k);
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (p1_pin.value[b] !== 1'b1 && k < 300);
    if (k == 300) begin
      err_total++;
      $display("[FAIL] zero-count pulse expected 1 seen none");
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    io_req = '0;
    {int_ack, int_return, sel} = 3'h0;
    daisy_in = 1'b1;
    p1_ext = 8'h3C;
    p2_ext = 8'h3C;
    {err_total, compares, cycles, n} = '0;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    check8("p1 oe_n", 8'hFF, p1_pin.oe_n);
    check8("p2 oe_n", 8'hFF, p2_pin.oe_n);
    for (int p = 0; p < 2; p++) begin
      wr(8'hE0 + 8'(2 * p), 8'h0F);
      wr(8'hE1 + 8'(2 * p), 8'hA5);
    end
    wr(8'hE8, 8'hFF);
    repeat (6) @(negedge core_clk);
    check8("p1 oe_n", 8'hF0, p1_pin.oe_n);
    check8("p2 oe_n", 8'hF0, p2_pin.oe_n);
    check8("p2 value", 8'h05, p2_pin.value & 8'h0F);
    for (int p = 0; p < 2; p++) begin
      rdchk(8'hE0 + 8'(2 * p), 8'h0F, "dir");
      rdchk(8'hE1 + 8'(2 * p), 8'h35, "data");
    end
    rdchk(8'hE8, 8'h00, "unmapped");
    $display("Ports test done");
    sel = 1'b1;
    wr(8'hE4, 8'hA8);
    for (int c = 0; c < 4; c++) begin
      wr(8'hE4 + 8'(c), 8'h85);
      wr(8'hE4 + 8'(c), 8'h02);
      check8("p1 oe_n timer", 8'h0F, p1_pin.oe_n);
      wait_zc(4 + c, n);
      wait_zc(4 + c, n);
      check8("zc period", 8'h20, 8'(n));
      n = 0;
      while (int_req !== 1'b1 && n < 100) begin
        @(negedge core_clk);
        n++;
      end
      check8("int_req", 8'h01, {7'h00, int_req});
      pulse(1'b1);
      wr(8'hE4 + 8'(c), 8'h03);
      check8("vector", 8'hA8 | 8'(c << 1), int_vector);
      check8("chain in service", 8'h00, {7'h00, daisy_out});
      pulse(1'b0);
    end
    $display("Timer test done");
    repeat (6) @(negedge core_clk);
    check8("chain open", 8'h01, {7'h00, daisy_out});
    daisy_in = 1'b0;
    repeat (6) @(negedge core_clk);
    check8("chain closed", 8'h00, {7'h00, daisy_out});
    daisy_in = 1'b1;
    wr(8'hE6, 8'h25);
    wr(8'hE6, 8'h01);
    wait_zc(6, n);
    wait_zc(6, n);
    check8("zc long period", 8'h80, 8'(n / 2));
    $display("Prescaler test done");
    wr(8'hE5, 8'h55);
    wr(8'hE5, 8'h03);
    wr(8'hE7, 8'h45);
    wr(8'hE7, 8'h03);
    p1_ext[1] = 1'b1;
    p1_ext[3] = 1'b0;
    repeat (8) @(negedge core_clk);
    p1_ext[1] = 1'b0;
    p1_ext[3] = 1'b1;
    repeat (8) @(negedge core_clk);
    rdchk(8'hE5, 8'h02, "rising trigger count");
    rdchk(8'hE7, 8'h02, "falling trigger count");
    $display("Counter test done");
    results();
  end
endmodule
